/* File: inc/owd_cfg.svh */
// Timing, field and reset constants of the one-wire dimming control block.
`ifndef OWD_CFG_SVH
`define OWD_CFG_SVH

// ********************************************************************
// Clock and switching oscillator
// ********************************************************************
`define OWD_CLK_MHZ 10
`define OWD_SW_FREQ_KHZ 600
`define OWD_FAULT_PERSIST 8

// ********************************************************************
// Line timing, in nanoseconds
// ********************************************************************
`define OWD_T_START_MIN_NS 2000
`define OWD_END_OF_STREAM_TIME_MIN_NS 2000
`define OWD_T_PHASE_MAX_NS 360000
`define OWD_T_ACK_VALID_MAX_NS 2000
`define OWD_T_ACK_MAX_NS 512000
`define OWD_T_OFF_MIN_NS 2500000
`define OWD_T_DET_MIN_NS 260000
`define OWD_T_DELAY_MIN_NS 100000
`define OWD_T_WIN_MIN_NS 1000000
`define OWD_T_HALF_LIM_NS 5000000
`define OWD_T_STEP_NS 213000

// ********************************************************************
// Stream layout and reset values
// ********************************************************************
`define OWD_STREAM_BITS 16
// The device address is an arbitrary value of our own choosing.
`define OWD_DEV_ADDR 8'h5A
`define OWD_SUB_ADDR 2'h0
`define OWD_ACK_REQ_BIT 7
`define OWD_SUB_HI 6
`define OWD_SUB_LO 5
`define OWD_LEVEL_HI 4
`define OWD_LEVEL_RESET 5'h1F
`define OWD_RAMP_STEPS 32

`endif

/* File: inc/owd_pkg.sv */
// Types shared by the one-wire dimming control block.
package owd_pkg;
    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_DETECT,
        ST_PWM,
        ST_ONE_WIRE,
        ST_FAULT
    } owd_state_e;
    typedef logic [4:0] owd_level_t;
endpackage : owd_pkg

/* File: src/owd_ctrl.sv */
// Control-pin logic: enable, mode detection, stream decode, acknowledge, soft start.
`include "owd_cfg.svh"
module owd_ctrl #(
    parameter int ACK_CYC = (`OWD_T_ACK_MAX_NS * `OWD_CLK_MHZ) / 1000,
    parameter int WIN_CYC = (`OWD_T_WIN_MIN_NS * `OWD_CLK_MHZ + 999) / 1000,
    parameter int OFF_CYC = (`OWD_T_OFF_MIN_NS * `OWD_CLK_MHZ + 999) / 1000,
    parameter int HALF_CYC = (`OWD_T_HALF_LIM_NS * `OWD_CLK_MHZ + 999) / 1000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ctrl_in,
    output logic ctrl_out,
    output logic ctrl_oe,
    input wire logic switch_node_ovp,
    input wire logic feedback_node_low,
    output logic switch_enable,
    output logic switch_tick,
    output owd_pkg::owd_level_t ref_code,
    output owd_pkg::owd_level_t level_code,
    output logic limit_half,
    output logic one_wire_mode,
    output logic pwm_mode,
    output logic fault_off,
    output owd_pkg::owd_state_e mode_state
);
    import owd_pkg::*;

    localparam int EOS_CYC = (`OWD_END_OF_STREAM_TIME_MIN_NS * `OWD_CLK_MHZ + 999) / 1000;
    localparam int PHASE_MAX_CYC = (`OWD_T_PHASE_MAX_NS * `OWD_CLK_MHZ) / 1000;
    localparam int DLY_CYC = (`OWD_T_DELAY_MIN_NS * `OWD_CLK_MHZ + 999) / 1000;
    localparam int DET_CYC = (`OWD_T_DET_MIN_NS * `OWD_CLK_MHZ + 999) / 1000;
    localparam int STEP_CYC = (`OWD_T_STEP_NS * `OWD_CLK_MHZ) / 1000;
    localparam int SW_DIV = (`OWD_CLK_MHZ * 1000) / `OWD_SW_FREQ_KHZ;

    if (ACK_CYC < 1 || ACK_CYC > 65535 || OFF_CYC < 2 || OFF_CYC > 65535 ||
        HALF_CYC > 65535 || WIN_CYC <= DLY_CYC + DET_CYC || WIN_CYC > HALF_CYC) begin : g_chk
        $error("owd_ctrl: timing parameters out of range");
    end

    owd_state_e state_r;
    logic ctrl_s1_r, ctrl_s2_r, ctrl_d_r;
    logic ovp_s1_r, ovp_s2_r, fbl_s1_r, fbl_s2_r;
    logic ack_r;
    logic [1:0] ack_tail_r;
    logic [15:0] ack_cnt_r, off_cnt_r, run_cnt_r, det_cnt_r, step_cnt_r;
    logic [11:0] phase_r, low_len_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] rx_r;
    logic in_bit_r;
    logic [4:0] soft_r;
    owd_level_t level_r;
    logic ignore, line_hi, rise, fall, off_hit, det_hit, running, fault_hit;
    logic stream_done, stream_ok, rx_bit;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_s1_r <= 1'b0;
            ctrl_s2_r <= 1'b0;
            ctrl_d_r <= 1'b0;
            ovp_s1_r <= 1'b0;
            ovp_s2_r <= 1'b0;
            fbl_s1_r <= 1'b0;
            fbl_s2_r <= 1'b0;
        end else begin
            ctrl_s1_r <= ctrl_in;
            ctrl_s2_r <= ctrl_s1_r;
            ctrl_d_r <= ctrl_s2_r;
            ovp_s1_r <= switch_node_ovp;
            ovp_s2_r <= ovp_s1_r;
            fbl_s1_r <= feedback_node_low;
            fbl_s2_r <= fbl_s1_r;
        end
    end

    // Our own acknowledge pulls the line low; it and its trip through the
    // synchroniser must not be read as host activity.
    assign ignore = ack_r | (ack_tail_r != 2'h0);
    assign line_hi = ctrl_s2_r;
    assign rise = line_hi & ~ctrl_d_r & ~ignore;
    assign fall = ~line_hi & ctrl_d_r & ~ignore;
    assign running = (state_r == ST_DETECT) || (state_r == ST_PWM) ||
                     (state_r == ST_ONE_WIRE);
    assign off_hit = ~line_hi & ~ignore & (off_cnt_r == 16'(OFF_CYC - 1));
    assign det_hit = ~line_hi & (det_cnt_r == 16'(DET_CYC - 1));
    assign rx_bit = phase_r > low_len_r;

    owd_open_led #(
        .DIV(SW_DIV),
        .PERSIST(`OWD_FAULT_PERSIST)
    ) u_open_led (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(running),
        .ovp(ovp_s2_r),
        .fb_low(fbl_s2_r),
        .sw_tick(switch_tick),
        .fault(fault_hit)
    );

    // ****************************************************************
    // Operating state
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            off_cnt_r <= 16'h0000;
        end else if (line_hi || ignore || off_hit) begin
            off_cnt_r <= 16'h0000;
        end else begin
            off_cnt_r <= off_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_SHUTDOWN;
        end else if (off_hit && state_r != ST_SHUTDOWN) begin
            state_r <= ST_SHUTDOWN;
        end else if (fault_hit && running) begin
            state_r <= ST_FAULT;
        end else begin
            unique case (state_r)
                ST_SHUTDOWN: begin
                    if (rise) begin
                        state_r <= ST_DETECT;
                    end
                end
                ST_DETECT: begin
                    if (det_hit) begin
                        state_r <= ST_ONE_WIRE;
                    end else if (run_cnt_r == 16'(WIN_CYC - 1)) begin
                        state_r <= ST_PWM;
                    end
                end
                ST_PWM, ST_ONE_WIRE, ST_FAULT: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Run time since enable: serves the detection window, the half limit
    // and nothing in shutdown, so a restart always begins from zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_cnt_r <= 16'h0000;
            det_cnt_r <= 16'h0000;
            limit_half <= 1'b0;
        end else if (!running) begin
            run_cnt_r <= 16'h0000;
            det_cnt_r <= 16'h0000;
            limit_half <= 1'b0;
        end else begin
            if (run_cnt_r < 16'(HALF_CYC)) begin
                run_cnt_r <= run_cnt_r + 16'h0001;
            end
            limit_half <= run_cnt_r < 16'(HALF_CYC - 1);
            if (state_r == ST_DETECT && !line_hi && run_cnt_r >= 16'(DLY_CYC)) begin
                det_cnt_r <= det_cnt_r + 16'h0001;
            end else begin
                det_cnt_r <= 16'h0000;
            end
        end
    end

    // ****************************************************************
    // Soft-start ramp
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step_cnt_r <= 16'h0000;
            soft_r <= 5'h00;
        end else if (!running) begin
            step_cnt_r <= 16'h0000;
            soft_r <= 5'h00;
        end else if (step_cnt_r == 16'(STEP_CYC - 1)) begin
            step_cnt_r <= 16'h0000;
            if (soft_r != 5'(`OWD_RAMP_STEPS - 1)) begin
                soft_r <= soft_r + 5'h01;
            end
        end else begin
            step_cnt_r <= step_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_code <= 5'h00;
        end else if (!running) begin
            ref_code <= 5'h00;
        end else begin
            ref_code <= (soft_r < level_r) ? soft_r : level_r;
        end
    end

    // ****************************************************************
    // Stream decoder
    // ****************************************************************
    assign stream_done = (state_r == ST_ONE_WIRE) && in_bit_r && !ignore && !line_hi &&
                         (bit_cnt_r == 5'(`OWD_STREAM_BITS)) &&
                         (phase_r == 12'(EOS_CYC - 1));
    assign stream_ok = stream_done && (rx_r[15:8] == `OWD_DEV_ADDR) &&
                       (rx_r[`OWD_SUB_HI:`OWD_SUB_LO] == `OWD_SUB_ADDR);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_r <= 12'h000;
            low_len_r <= 12'h000;
            bit_cnt_r <= 5'h00;
            rx_r <= 16'h0000;
            in_bit_r <= 1'b0;
        end else if (state_r != ST_ONE_WIRE || ignore || stream_done) begin
            phase_r <= 12'h000;
            in_bit_r <= 1'b0;
            bit_cnt_r <= 5'h00;
        end else if (fall) begin
            phase_r <= 12'h000;
            in_bit_r <= 1'b1;
            if (!in_bit_r) begin
                bit_cnt_r <= 5'h00;
            end else if (bit_cnt_r == 5'(`OWD_STREAM_BITS)) begin
                in_bit_r <= 1'b0;
            end else begin
                rx_r <= {rx_r[14:0], rx_bit};
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end else if (rise) begin
            low_len_r <= phase_r;
            phase_r <= 12'h000;
        end else if (phase_r == 12'(PHASE_MAX_CYC)) begin
            in_bit_r <= 1'b0;
            bit_cnt_r <= 5'h00;
        end else begin
            phase_r <= phase_r + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            level_r <= `OWD_LEVEL_RESET;
        end else if (stream_ok) begin
            level_r <= rx_r[`OWD_LEVEL_HI:0];
        end
    end

    // ****************************************************************
    // Acknowledge driver
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            ack_cnt_r <= 16'h0000;
            ack_tail_r <= 2'h0;
        end else if (ack_r) begin
            ack_cnt_r <= ack_cnt_r + 16'h0001;
            if (ack_cnt_r == 16'(ACK_CYC - 1) || state_r != ST_ONE_WIRE) begin
                ack_r <= 1'b0;
                ack_tail_r <= 2'h3;
            end
        end else begin
            ack_cnt_r <= 16'h0000;
            ack_r <= stream_ok && rx_r[`OWD_ACK_REQ_BIT];
            if (ack_tail_r != 2'h0) begin
                ack_tail_r <= ack_tail_r - 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            switch_enable <= 1'b0;
            one_wire_mode <= 1'b0;
            pwm_mode <= 1'b0;
            fault_off <= 1'b0;
        end else begin
            switch_enable <= running && !fault_hit;
            one_wire_mode <= state_r == ST_ONE_WIRE;
            pwm_mode <= state_r == ST_DETECT || state_r == ST_PWM;
            fault_off <= state_r == ST_FAULT;
        end
    end

    assign ctrl_out = 1'b0;
    assign ctrl_oe = ack_r;
    assign level_code = level_r;
    assign mode_state = state_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_ack_req;
        $rose(ctrl_oe) |-> $past(stream_ok) && $past(rx_r[`OWD_ACK_REQ_BIT]);
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");

    property p_ack_valid;
        stream_ok && rx_r[`OWD_ACK_REQ_BIT] && state_r == ST_ONE_WIRE |-> ##[1:2] ctrl_oe;
    endproperty
    a_ack_valid: assert property (p_ack_valid) else $error("ack late");

    property p_ack_len;
        ctrl_oe |-> ack_cnt_r < 16'(ACK_CYC);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too long");

    property p_off;
        off_hit && state_r != ST_SHUTDOWN |=> state_r == ST_SHUTDOWN ##2 !switch_enable;
    endproperty
    a_off: assert property (p_off) else $error("no shutdown on long low");

    property p_step;
        running && $changed(soft_r) && $past(running) |-> $past(step_cnt_r) == 16'(STEP_CYC - 1);
    endproperty
    a_step: assert property (p_step) else $error("ramp step timing");

    property p_half;
        running && $past(running) && run_cnt_r == 16'(HALF_CYC) |=> !limit_half;
    endproperty
    a_half: assert property (p_half) else $error("half limit too long");

    property p_fault;
        fault_hit && running && !off_hit |=> state_r == ST_FAULT ##1 !switch_enable;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not taken");

    property p_fault_hold;
        state_r == ST_FAULT && !off_hit |=> state_r == ST_FAULT;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault left early");

    property p_mode_hold;
        state_r == ST_PWM |=> state_r inside {ST_PWM, ST_SHUTDOWN, ST_FAULT};
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

    property p_level;
        stream_ok |=> level_r == $past(rx_r[`OWD_LEVEL_HI:0]) ##2 ref_code <= level_r;
    endproperty
    a_level: assert property (p_level) else $error("level not taken");
endmodule : owd_ctrl

/* File: src/owd_open_led.sv */
// Switching oscillator tick and open-LED fault filter.
`include "owd_cfg.svh"
module owd_open_led #(
    parameter int DIV = 16,
    parameter int PERSIST = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic ovp,
    input wire logic fb_low,
    output logic sw_tick,
    output logic fault
);
    logic [7:0] div_r;
    logic [7:0] hit_r;

    if (DIV < 2 || DIV > 255 || PERSIST < 1 || PERSIST > 255) begin : g_chk
        $error("owd_open_led: DIV or PERSIST out of range");
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= 8'h00;
            sw_tick <= 1'b0;
        end else if (!run) begin
            div_r <= 8'h00;
            sw_tick <= 1'b0;
        end else begin
            div_r <= (div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01;
            sw_tick <= (div_r == 8'(DIV - 1));
        end
    end

    // ****************************************************************
    // Fault persistence, one sample per switching cycle
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hit_r <= 8'h00;
            fault <= 1'b0;
        end else if (!run) begin
            hit_r <= 8'h00;
            fault <= 1'b0;
        end else if (sw_tick) begin
            if (ovp && fb_low) begin
                hit_r <= hit_r + 8'h01;
                fault <= (hit_r == 8'(PERSIST - 1));
            end else begin
                hit_r <= 8'h00;
                fault <= 1'b0;
            end
        end else begin
            fault <= 1'b0;
        end
    end
endmodule : owd_open_led

/* File: test/owd_host.sv */
// Host model that drives the control line through an open-drain pull-down.
module owd_host (
    input wire logic ref_clk,
    output logic drv_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Line driving
    // ****************************************************************
    // The host only pulls down; the resistor returns the line high.
    initial drv_low = 1'b1;
    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : step
    task automatic hold(input logic lvl, input int n);
        drv_low = ~lvl;
        step(n);
    endtask : hold
    task automatic send_bit(input logic b, input int unit, input int longer);
        if (b) begin
            hold(1'b0, unit);
            hold(1'b1, longer);
        end else begin
            hold(1'b0, longer);
            hold(1'b1, unit);
        end
    endtask : send_bit
    // Returns at the fall that opens the end of stream, so the caller can time the answer.
    task automatic send_stream(input logic [15:0] word, input int nbits, input int unit);
        hold(1'b1, 40);
        for (int i = 15; i > 15 - nbits; i--) begin
            send_bit(word[i], unit, 2 * unit + $urandom_range(0, 20));
        end
        drv_low = 1'b1;
    endtask : send_stream
endmodule : owd_host

/* File: test/tb_top.sv */
// Self-checking testbench of the one-wire dimming control block.
`include "owd_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import owd_pkg::*;
    // ****************************************************************
    // Set-up
    // ****************************************************************
    localparam int ACK = 200;
    localparam int WIN = 10000;
    localparam int OFF = 6000;
    localparam int HALF = 10000;
    localparam int STEP = 2130;
    logic ref_clk, rst, switch_node_ovp, feedback_node_low;
    logic ctrl_out, ctrl_oe, switch_enable, switch_tick, limit_half;
    logic one_wire_mode, pwm_mode, fault_off, drv_low;
    owd_level_t ref_code, level_code;
    owd_state_e mode_state;
    wire logic line = (ctrl_oe ? ctrl_out : 1'b1) & ~drv_low;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int exp_level = 31;
    bit one_wire_exp = 0;
    owd_host host_inst (.ref_clk(ref_clk), .drv_low(drv_low));
    owd_ctrl #(.ACK_CYC(ACK), .OFF_CYC(OFF), .HALF_CYC(HALF)) owd_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .ctrl_in(line), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe),
        .switch_node_ovp(switch_node_ovp), .feedback_node_low(feedback_node_low),
        .switch_enable(switch_enable), .switch_tick(switch_tick), .ref_code(ref_code),
        .level_code(level_code), .limit_half(limit_half), .one_wire_mode(one_wire_mode),
        .pwm_mode(pwm_mode), .fault_off(fault_off), .mode_state(mode_state));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            $display("run did not finish in time");
            print_verdict();
        end
    end
    task automatic bad(input logic [31:0] got, input logic [31:0] exp);
        fails++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask : bad
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) bad(32'(got), 32'(exp));
    endtask : check_bit
    task automatic check_level(input owd_level_t got, input owd_level_t exp);
        samples_checked++;
        if (got !== exp) bad(32'(got), 32'(exp));
    endtask : check_level
    task automatic check_state(input owd_state_e got, input owd_state_e exp);
        samples_checked++;
        if (got !== exp) bad(32'(got), 32'(exp));
    endtask : check_state
    task automatic check_count(input int got, input int exp);
        samples_checked++;
        if (got != exp) bad(32'(got), 32'(exp));
    endtask : check_count
    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask : end_test
    // The bench model decides acceptance from the word, its bit count and whether one-wire mode is expected.
    task automatic run_stream(input logic [15:0] word, input int nbits, input int unit);
        int rise_at, ack_len, guard;
        bit accept;
        rise_at = -1;
        ack_len = 0;
        guard = 0;
        accept = one_wire_exp && nbits == 16 && word[15:8] == `OWD_DEV_ADDR
            && word[6:5] == `OWD_SUB_ADDR;
        host_inst.send_stream(word, nbits, unit);
        for (int i = 1; i <= 40; i++) begin
            host_inst.step(1);
            if (ctrl_oe === 1'b1) begin
                ack_len++;
                if (rise_at < 0) rise_at = i;
            end
        end
        host_inst.hold(1'b1, 0);
        while (ctrl_oe === 1'b1 && guard < 6000) begin
            host_inst.step(1);
            guard++;
            if (ctrl_oe === 1'b1) ack_len++;
        end
        host_inst.step(5);
        // A short stream is only dropped once a phase outlasts the longest legal one.
        if (nbits != 16) host_inst.step(3700);
        if (accept) exp_level = int'(word[4:0]);
        check_count(ack_len, (accept && word[7]) ? ACK : 0);
        if (accept && word[7]) check_bit(rise_at >= 20 && rise_at <= 25, 1'b1);
        check_bit(line, 1'b1);
        check_level(level_code, owd_level_t'(exp_level));
    endtask : run_stream
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        int seed_val, t1, t2, half_len, n;
        logic [7:0] addr;
        owd_level_t prev;
        rst = 1'b1;
        switch_node_ovp = 1'b0;
        feedback_node_low = 1'b0;
        seed_val = $urandom(32'h345A);
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        check_level(level_code, 5'h1F);
        check_state(mode_state, ST_SHUTDOWN);
        check_bit(switch_enable, 1'b0);
        end_test("reset");
        host_inst.hold(1'b1, 5);
        check_bit(pwm_mode, 1'b1);
        check_bit(limit_half, 1'b1);
        host_inst.hold(1'b1, 1100);
        host_inst.hold(1'b0, 2700);
        host_inst.hold(1'b1, 10);
        one_wire_exp = 1;
        check_bit(one_wire_mode, 1'b1);
        check_bit(pwm_mode, 1'b0);
        end_test("detect");
        for (int i = 0; i < 6; i++) begin
            addr = (i == 2) ? (`OWD_DEV_ADDR ^ 8'h01) : `OWD_DEV_ADDR;
            run_stream({addr, i != 1, (i == 3) ? 2'h1 : `OWD_SUB_ADDR,
                5'($urandom_range(3, 31))}, (i == 4) ? 15 : 16,
                (i == 0) ? 20 : $urandom_range(20, 120));
        end
        end_test("streams");
        host_inst.hold(1'b0, OFF - 50);
        check_bit(switch_enable, 1'b1);
        host_inst.hold(1'b0, 100);
        one_wire_exp = 0;
        check_state(mode_state, ST_SHUTDOWN);
        check_bit(switch_enable, 1'b0);
        check_level(level_code, owd_level_t'(exp_level));
        end_test("shutdown");
        t1 = -1;
        t2 = -1;
        half_len = 0;
        prev = ref_code;
        for (int c = 1; c <= HALF + 200; c++) begin
            host_inst.hold(1'b1, 1);
            // Either comparator alone must never trip the open-LED filter.
            {switch_node_ovp, feedback_node_low} = 2'($urandom_range(0, 2));
            if (limit_half === 1'b1) half_len++;
            if (ref_code !== prev && t1 >= 0 && t2 < 0) t2 = c;
            if (ref_code !== prev && t1 < 0) t1 = c;
            prev = ref_code;
            if (c == WIN + 10) check_bit(pwm_mode & ~one_wire_mode, 1'b1);
            if (c == WIN + 10) check_state(mode_state, ST_PWM);
        end
        check_bit(fault_off, 1'b0);
        check_count(t2 - t1, STEP);
        check_bit(half_len >= HALF - 4 && half_len <= HALF + 4, 1'b1);
        check_level(ref_code, owd_level_t'((exp_level < 4) ? exp_level : 4));
        run_stream({`OWD_DEV_ADDR, 1'b1, `OWD_SUB_ADDR, 5'h02}, 16, 40);
        end_test("pwm start");
        n = 0;
        while (switch_tick !== 1'b1 && n < 40) begin
            host_inst.step(1);
            n++;
        end
        n = 0;
        do begin
            host_inst.step(1);
            n++;
        end while (switch_tick !== 1'b1 && n < 40);
        check_count(n, 16);
        switch_node_ovp = 1'b1;
        feedback_node_low = 1'b1;
        host_inst.step(96);
        switch_node_ovp = 1'b0;
        host_inst.step(100);
        check_bit(fault_off, 1'b0);
        switch_node_ovp = 1'b1;
        n = 0;
        while (fault_off !== 1'b1 && n < 300) begin
            host_inst.step(1);
            n++;
        end
        check_bit(n > 7 * 16 && n <= 9 * 16 + 6, 1'b1);
        check_bit(switch_enable, 1'b0);
        check_state(mode_state, ST_FAULT);
        switch_node_ovp = 1'b0;
        feedback_node_low = 1'b0;
        host_inst.hold(1'b0, 1000);
        host_inst.hold(1'b1, 50);
        check_bit(fault_off, 1'b1);
        check_bit(switch_enable, 1'b0);
        host_inst.hold(1'b0, OFF + 20);
        check_state(mode_state, ST_SHUTDOWN);
        host_inst.hold(1'b1, 5);
        check_bit(pwm_mode & switch_enable & ~fault_off, 1'b1);
        end_test("fault");
        print_verdict();
    end
endmodule : tb_top
